// file: rtl/rcd_decode.sv
// instruction decoder: classifies each fetched word and tracks delay slots
// assumes fetch and the execution pipeline share clk_in; no pin inputs
//
// Behaviour
// - every instruction is one fixed 32-bit word
// - three formats, immediate, jump, register, select the field extraction
// - loads and stores are immediate-format register/memory transfers
// - memory address is base register plus sign-extended 16-bit offset only
// - register ALU ops read one or two sources and write one destination
// - immediate ALU ops take a 16-bit immediate and one register
// - computational ops split into ALU-imm, ALU-reg, shift, multiply/divide
// - doubleword +32 shifts add 32 to the encoded shift amount
// - set-less-than exists signed and unsigned, register and immediate
// - add and add-immediate also exist in 64-bit doubleword forms
// - jumps and branches have one delay slot, which always executes except after a branch-likely
// - branch-likely slot instruction is nullified when the branch is not taken
// - branches test equal, not equal, or one register against zero
`timescale 1ns/1ps
`default_nettype none

module rcd_decode (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic ce_in,
  input wire logic instr_valid_in,
  input wire logic [31:0] instr_in,
  input wire logic br_resolve_in,
  input wire logic br_taken_in,
  output logic dec_valid_out,
  output var rcd_pkg::rcd_ctrl_t dec_out,
  output logic dec_slot_out,
  output logic dec_nullify_out
);

  rcd_pkg::rcd_fields_t f;
  rcd_pkg::rcd_ctrl_t ctrl_d;
  rcd_pkg::rcd_ctrl_t dec_q;
  rcd_pkg::rcd_slot_t slot_q;
  logic valid_q;
  logic slot_flag_q;
  logic lk_pend_q;
  logic null_q;
  logic take;
  logic is_ctl;

  rcd_field_split u_split (
    .instr_in(instr_in),
    .fields_out(f)
  );

  // ----------------------------------------------------------------------
  // combinational classification
  // ----------------------------------------------------------------------
  always_comb begin
    ctrl_d = '0;
    ctrl_d.fmt = f.fmt;
    ctrl_d.opcode = f.opcode;
    ctrl_d.funct = f.funct;
    ctrl_d.rs = f.rs;
    ctrl_d.rt = f.rt;
    ctrl_d.target = f.target;
    ctrl_d.imm = {{48{f.imm[15]}}, f.imm};
    case (f.opcode)
      rcd_pkg::OP_SPECIAL: begin
        ctrl_d.dst = f.rd;
        ctrl_d.wr_en = 1'b1;
        ctrl_d.shamt = {1'b0, f.shamt};
        case (f.funct)
          rcd_pkg::FN_SLL, rcd_pkg::FN_SRL, rcd_pkg::FN_SRA: begin
            ctrl_d.grp = rcd_pkg::RCD_GRP_SHIFT;
          end
          rcd_pkg::FN_SLLV, rcd_pkg::FN_SRLV, rcd_pkg::FN_SRAV: begin
            ctrl_d.grp = rcd_pkg::RCD_GRP_SHIFT;
            ctrl_d.shift_var = 1'b1;
          end
          rcd_pkg::FN_DSLLV, rcd_pkg::FN_DSRLV, rcd_pkg::FN_DSRAV: begin
            ctrl_d.grp = rcd_pkg::RCD_GRP_SHIFT;
            ctrl_d.shift_var = 1'b1;
            ctrl_d.dword = 1'b1;
          end
          rcd_pkg::FN_DSLL, rcd_pkg::FN_DSRL, rcd_pkg::FN_DSRA: begin
            ctrl_d.grp = rcd_pkg::RCD_GRP_SHIFT;
            ctrl_d.dword = 1'b1;
          end
          rcd_pkg::FN_DWORD_SHIFT_LEFT_PLUS32, rcd_pkg::FN_DWORD_SHIFT_RIGHT_LOGICAL_PLUS32,
          rcd_pkg::FN_DWORD_SHIFT_RIGHT_ARITH_PLUS32: begin
            ctrl_d.grp = rcd_pkg::RCD_GRP_SHIFT;
            ctrl_d.dword = 1'b1;
            ctrl_d.shamt = {1'b0, f.shamt} + rcd_pkg::SHAMT_PLUS32;
          end
          rcd_pkg::FN_JR: begin
            ctrl_d.grp = rcd_pkg::RCD_GRP_JUMP;
            ctrl_d.cond = rcd_pkg::RCD_CND_ALWAYS;
            ctrl_d.wr_en = 1'b0;
          end
          rcd_pkg::FN_JALR: begin
            ctrl_d.grp = rcd_pkg::RCD_GRP_JUMP;
            ctrl_d.cond = rcd_pkg::RCD_CND_ALWAYS;
            ctrl_d.link = 1'b1;
          end
          rcd_pkg::FN_SYNC: begin
            ctrl_d.grp = rcd_pkg::RCD_GRP_SYNC;
            ctrl_d.wr_en = 1'b0;
          end
          rcd_pkg::FN_MFHI, rcd_pkg::FN_MFLO: begin
            ctrl_d.grp = rcd_pkg::RCD_GRP_MULDIV;
          end
          rcd_pkg::FN_MTHI, rcd_pkg::FN_MTLO, rcd_pkg::FN_MULT, rcd_pkg::FN_MULTU,
          rcd_pkg::FN_DIV, rcd_pkg::FN_DIVU: begin
            ctrl_d.grp = rcd_pkg::RCD_GRP_MULDIV;
            ctrl_d.wr_en = 1'b0;
            ctrl_d.unsigned_op = f.funct[0];
          end
          rcd_pkg::FN_DMULT, rcd_pkg::FN_DMULTU, rcd_pkg::FN_DDIV, rcd_pkg::FN_DDIVU: begin
            ctrl_d.grp = rcd_pkg::RCD_GRP_MULDIV;
            ctrl_d.wr_en = 1'b0;
            ctrl_d.dword = 1'b1;
            ctrl_d.unsigned_op = f.funct[0];
          end
          rcd_pkg::FN_ADD, rcd_pkg::FN_ADDU, rcd_pkg::FN_SUB, rcd_pkg::FN_SUBU,
          rcd_pkg::FN_AND, rcd_pkg::FN_OR, rcd_pkg::FN_XOR, rcd_pkg::FN_NOR: begin
            ctrl_d.grp = rcd_pkg::RCD_GRP_ALU_REG;
            ctrl_d.unsigned_op = (f.funct == rcd_pkg::FN_ADDU) || (f.funct == rcd_pkg::FN_SUBU);
          end
          rcd_pkg::FN_SET_LESS_THAN, rcd_pkg::FN_SLTU: begin
            ctrl_d.grp = rcd_pkg::RCD_GRP_ALU_REG;
            ctrl_d.unsigned_op = f.funct[0];
          end
          rcd_pkg::FN_DADD, rcd_pkg::FN_DADDU, rcd_pkg::FN_DSUB, rcd_pkg::FN_DSUBU: begin
            ctrl_d.grp = rcd_pkg::RCD_GRP_ALU_REG;
            ctrl_d.dword = 1'b1;
            ctrl_d.unsigned_op = f.funct[0];
          end
          default: begin
            ctrl_d.wr_en = 1'b0;
            ctrl_d.reserved = 1'b1;
          end
        endcase
      end
      rcd_pkg::OP_REGIMM: begin
        ctrl_d.grp = rcd_pkg::RCD_GRP_BRANCH;
        ctrl_d.cond = f.rt[0] ? rcd_pkg::RCD_CND_GEZ : rcd_pkg::RCD_CND_LTZ;
        ctrl_d.likely = f.rt[1];
        ctrl_d.link = f.rt[4];
        ctrl_d.wr_en = f.rt[4];
        ctrl_d.dst = f.rt[4] ? rcd_pkg::LINK_REG : 5'h00;
        case (f.rt)
          rcd_pkg::RI_BLTZ, rcd_pkg::RI_BGEZ, rcd_pkg::RI_BLTZL, rcd_pkg::RI_BGEZL,
          rcd_pkg::RI_BLTZAL, rcd_pkg::RI_BGEZAL, rcd_pkg::RI_BLTZALL, rcd_pkg::RI_BGEZALL: begin
            ctrl_d.reserved = 1'b0;
          end
          default: begin
            ctrl_d = '0;
            ctrl_d.fmt = f.fmt;
            ctrl_d.opcode = f.opcode;
            ctrl_d.reserved = 1'b1;
          end
        endcase
      end
      rcd_pkg::OP_J, rcd_pkg::OP_JUMP_WITH_LINK: begin
        ctrl_d.grp = rcd_pkg::RCD_GRP_JUMP;
        ctrl_d.cond = rcd_pkg::RCD_CND_ALWAYS;
        ctrl_d.imm = '0;
        ctrl_d.link = f.opcode[0];
        ctrl_d.wr_en = f.opcode[0];
        ctrl_d.dst = f.opcode[0] ? rcd_pkg::LINK_REG : 5'h00;
      end
      rcd_pkg::OP_BEQ, rcd_pkg::OP_BNE, rcd_pkg::OP_BRANCH_LE_ZERO, rcd_pkg::OP_BGTZ,
      rcd_pkg::OP_BRANCH_EQUAL_LIKELY, rcd_pkg::OP_BNEL, rcd_pkg::OP_BLEZL, rcd_pkg::OP_BGTZL: begin
        ctrl_d.grp = rcd_pkg::RCD_GRP_BRANCH;
        ctrl_d.likely = f.opcode[4];
        case (f.opcode[1:0])
          2'h0: ctrl_d.cond = rcd_pkg::RCD_CND_EQ;
          2'h1: ctrl_d.cond = rcd_pkg::RCD_CND_NE;
          2'h2: ctrl_d.cond = rcd_pkg::RCD_CND_LEZ;
          default: ctrl_d.cond = rcd_pkg::RCD_CND_GTZ;
        endcase
      end
      rcd_pkg::OP_ADDI, rcd_pkg::OP_ADDIU, rcd_pkg::OP_SLTI, rcd_pkg::OP_SET_LESS_THAN_IMM_UNSIGNED,
      rcd_pkg::OP_DADDI, rcd_pkg::OP_DWORD_ADD_IMM_UNSIGNED: begin
        ctrl_d.grp = rcd_pkg::RCD_GRP_ALU_IMM;
        ctrl_d.dst = f.rt;
        ctrl_d.wr_en = 1'b1;
        ctrl_d.unsigned_op = f.opcode[0];
        ctrl_d.dword = f.opcode[4];
      end
      rcd_pkg::OP_ANDI, rcd_pkg::OP_ORI, rcd_pkg::OP_XORI, rcd_pkg::OP_LUI: begin
        ctrl_d.grp = rcd_pkg::RCD_GRP_ALU_IMM;
        ctrl_d.dst = f.rt;
        ctrl_d.wr_en = 1'b1;
        // logical immediates zero-extend; the upper-immediate form lands in bits 31:16
        ctrl_d.imm = (f.opcode == rcd_pkg::OP_LUI) ? {{32{f.imm[15]}}, f.imm, 16'h0000} : {48'h0000_0000_0000, f.imm};
      end
      rcd_pkg::OP_LB, rcd_pkg::OP_LH, rcd_pkg::OP_LWL, rcd_pkg::OP_LW, rcd_pkg::OP_LBU,
      rcd_pkg::OP_LHU, rcd_pkg::OP_LWR, rcd_pkg::OP_LWU, rcd_pkg::OP_LDL, rcd_pkg::OP_LDR,
      rcd_pkg::OP_LL, rcd_pkg::OP_LLD, rcd_pkg::OP_LD: begin
        ctrl_d.grp = rcd_pkg::RCD_GRP_LOAD;
        ctrl_d.dst = f.rt;
        ctrl_d.wr_en = 1'b1;
      end
      rcd_pkg::OP_SB, rcd_pkg::OP_SH, rcd_pkg::OP_SWL, rcd_pkg::OP_SW, rcd_pkg::OP_SDL,
      rcd_pkg::OP_SDR, rcd_pkg::OP_SWR, rcd_pkg::OP_SD, rcd_pkg::OP_SC, rcd_pkg::OP_SCD: begin
        ctrl_d.grp = rcd_pkg::RCD_GRP_STORE;
        // conditional stores write their success flag back into rt
        ctrl_d.dst = f.rt;
        ctrl_d.wr_en = (f.opcode == rcd_pkg::OP_SC) || (f.opcode == rcd_pkg::OP_SCD);
      end
      default: begin
        ctrl_d.imm = '0;
        ctrl_d.reserved = 1'b1;
      end
    endcase
  end

  assign take = ce_in && instr_valid_in;
  assign is_ctl = (ctrl_d.grp == rcd_pkg::RCD_GRP_JUMP) || (ctrl_d.grp == rcd_pkg::RCD_GRP_BRANCH);

  // ----------------------------------------------------------------------
  // decoded word register
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      dec_q <= '0;
      valid_q <= 1'b0;
    end else if (ce_in) begin
      valid_q <= instr_valid_in;
      if (instr_valid_in) begin
        dec_q <= ctrl_d;
      end
    end
  end

  // ----------------------------------------------------------------------
  // delay slot tracking
  // ----------------------------------------------------------------------
  // a control transfer found in a slot is not itself given a fresh slot flag
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      slot_q <= rcd_pkg::RCD_SLOT_IDLE;
      slot_flag_q <= 1'b0;
    end else if (ce_in) begin
      // the flag stands only with the slot word's own valid cycle
      slot_flag_q <= take && (slot_q != rcd_pkg::RCD_SLOT_IDLE);
      if (take) begin
        case (slot_q)
          rcd_pkg::RCD_SLOT_IDLE: begin
            if (is_ctl) begin
              slot_q <= ctrl_d.likely ? rcd_pkg::RCD_SLOT_NEXT_LIKELY : rcd_pkg::RCD_SLOT_NEXT;
            end
          end
          default: slot_q <= rcd_pkg::RCD_SLOT_IDLE;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // branch-likely nullification
  // ----------------------------------------------------------------------
  // a new likely branch in the resolve cycle re-arms the pending flag: set wins
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      lk_pend_q <= 1'b0;
      null_q <= 1'b0;
    end else if (ce_in) begin
      null_q <= br_resolve_in && lk_pend_q && !br_taken_in;
      if (take && is_ctl && ctrl_d.likely && slot_q == rcd_pkg::RCD_SLOT_IDLE) begin
        lk_pend_q <= 1'b1;
      end else if (br_resolve_in) begin
        lk_pend_q <= 1'b0;
      end
    end
  end

  assign dec_valid_out = valid_q;
  assign dec_out = dec_q;
  assign dec_slot_out = slot_flag_q;
  assign dec_nullify_out = null_q;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);

  a_word_taken: assert property (take |=> dec_valid_out) else $error("accepted word not presented");
  a_jump_format: assert property (take && instr_in[31:26] == rcd_pkg::OP_J |=>
    dec_out.fmt == rcd_pkg::RCD_FMT_J && dec_out.target == $past(instr_in[25:0])) else $error("jump format");
  a_mem_itype: assert property (dec_valid_out && (dec_out.grp == rcd_pkg::RCD_GRP_LOAD ||
    dec_out.grp == rcd_pkg::RCD_GRP_STORE) |-> dec_out.fmt == rcd_pkg::RCD_FMT_I) else $error("mem format");
  a_mem_offset: assert property (take && instr_in[31:26] == rcd_pkg::OP_LD |=>
    dec_out.imm == {{48{$past(instr_in[15])}}, $past(instr_in[15:0])}) else $error("offset extension");
  a_reg_dest: assert property (take && instr_in[31:26] == rcd_pkg::OP_SPECIAL && instr_in[5:0] == rcd_pkg::FN_ADD
    |=> dec_out.wr_en && dec_out.dst == $past(instr_in[15:11])) else $error("register destination");
  a_shift_plus32: assert property (take && instr_in[31:26] == rcd_pkg::OP_SPECIAL &&
    instr_in[5:0] == rcd_pkg::FN_DWORD_SHIFT_RIGHT_ARITH_PLUS32 |=>
    dec_out.shamt == {1'b1, $past(instr_in[10:6])}) else $error("plus32");
  a_slti_uns: assert property (take && instr_in[31:26] == rcd_pkg::OP_SET_LESS_THAN_IMM_UNSIGNED |=>
    dec_out.unsigned_op && dec_out.grp == rcd_pkg::RCD_GRP_ALU_IMM) else $error("unsigned compare");
  a_slot_follow: assert property (dec_valid_out && dec_out.grp == rcd_pkg::RCD_GRP_BRANCH && !dec_slot_out
    && take |=> dec_slot_out) else $error("delay slot not flagged");
  a_likely_null: assert property (ce_in && br_resolve_in && lk_pend_q |=>
    dec_nullify_out == !$past(br_taken_in)) else $error("nullify");
  a_le_zero_cond: assert property (take && instr_in[31:26] == rcd_pkg::OP_BRANCH_LE_ZERO |=>
    dec_out.cond == rcd_pkg::RCD_CND_LEZ && !dec_out.likely) else $error("branch condition");
  a_link_dest: assert property (take && instr_in[31:26] == rcd_pkg::OP_JUMP_WITH_LINK |=>
    dec_out.link && dec_out.dst == rcd_pkg::LINK_REG) else $error("link destination");
  a_reserved_flag: assert property (dec_valid_out && dec_out.grp == rcd_pkg::RCD_GRP_NONE |->
    dec_out.reserved) else $error("unclassified word not flagged");

endmodule

`default_nettype wire

// file: rtl/rcd_pkg.sv
// instruction decode package: field layout, opcodes, decoded control word
// assumes a 32-bit fixed instruction word and a 64-bit register datapath
package rcd_pkg;

  // ----------------------------------------------------------------------
  // widths and constants
  // ----------------------------------------------------------------------
  localparam int unsigned INSTR_W = 32;
  localparam int unsigned IMM_W = 16;
  localparam int unsigned DWORD_W = 64;
  localparam logic [5:0] SHAMT_PLUS32 = 6'h20;
  localparam logic [4:0] LINK_REG = 5'h1f;

  // ----------------------------------------------------------------------
  // primary opcodes
  // ----------------------------------------------------------------------
  localparam logic [5:0] OP_SPECIAL = 6'h00, OP_REGIMM = 6'h01, OP_J = 6'h02, OP_JUMP_WITH_LINK = 6'h03,
    OP_BEQ = 6'h04, OP_BNE = 6'h05, OP_BRANCH_LE_ZERO = 6'h06, OP_BGTZ = 6'h07,
    OP_ADDI = 6'h08, OP_ADDIU = 6'h09, OP_SLTI = 6'h0a, OP_SET_LESS_THAN_IMM_UNSIGNED = 6'h0b,
    OP_ANDI = 6'h0c, OP_ORI = 6'h0d, OP_XORI = 6'h0e, OP_LUI = 6'h0f,
    OP_BRANCH_EQUAL_LIKELY = 6'h14, OP_BNEL = 6'h15, OP_BLEZL = 6'h16, OP_BGTZL = 6'h17,
    OP_DADDI = 6'h18, OP_DWORD_ADD_IMM_UNSIGNED = 6'h19, OP_LDL = 6'h1a, OP_LDR = 6'h1b,
    OP_LB = 6'h20, OP_LH = 6'h21, OP_LWL = 6'h22, OP_LW = 6'h23,
    OP_LBU = 6'h24, OP_LHU = 6'h25, OP_LWR = 6'h26, OP_LWU = 6'h27,
    OP_SB = 6'h28, OP_SH = 6'h29, OP_SWL = 6'h2a, OP_SW = 6'h2b,
    OP_SDL = 6'h2c, OP_SDR = 6'h2d, OP_SWR = 6'h2e, OP_LL = 6'h30,
    OP_LLD = 6'h34, OP_LD = 6'h37, OP_SC = 6'h38, OP_SCD = 6'h3c, OP_SD = 6'h3f;

  // ----------------------------------------------------------------------
  // register-format function codes and regimm selectors
  // ----------------------------------------------------------------------
  localparam logic [5:0] FN_SLL = 6'h00, FN_SRL = 6'h02, FN_SRA = 6'h03, FN_SLLV = 6'h04,
    FN_SRLV = 6'h06, FN_SRAV = 6'h07, FN_JR = 6'h08, FN_JALR = 6'h09, FN_SYNC = 6'h0f,
    FN_MFHI = 6'h10, FN_MTHI = 6'h11, FN_MFLO = 6'h12, FN_MTLO = 6'h13,
    FN_DSLLV = 6'h14, FN_DSRLV = 6'h16, FN_DSRAV = 6'h17, FN_MULT = 6'h18, FN_MULTU = 6'h19,
    FN_DIV = 6'h1a, FN_DIVU = 6'h1b, FN_DMULT = 6'h1c, FN_DMULTU = 6'h1d, FN_DDIV = 6'h1e,
    FN_DDIVU = 6'h1f, FN_ADD = 6'h20, FN_ADDU = 6'h21, FN_SUB = 6'h22, FN_SUBU = 6'h23,
    FN_AND = 6'h24, FN_OR = 6'h25, FN_XOR = 6'h26, FN_NOR = 6'h27, FN_SET_LESS_THAN = 6'h2a,
    FN_SLTU = 6'h2b, FN_DADD = 6'h2c, FN_DADDU = 6'h2d, FN_DSUB = 6'h2e, FN_DSUBU = 6'h2f,
    FN_DSLL = 6'h38, FN_DSRL = 6'h3a, FN_DSRA = 6'h3b, FN_DWORD_SHIFT_LEFT_PLUS32 = 6'h3c,
    FN_DWORD_SHIFT_RIGHT_LOGICAL_PLUS32 = 6'h3e, FN_DWORD_SHIFT_RIGHT_ARITH_PLUS32 = 6'h3f;
  localparam logic [4:0] RI_BLTZ = 5'h00, RI_BGEZ = 5'h01, RI_BLTZL = 5'h02, RI_BGEZL = 5'h03,
    RI_BLTZAL = 5'h10, RI_BGEZAL = 5'h11, RI_BLTZALL = 5'h12, RI_BGEZALL = 5'h13;

  // ----------------------------------------------------------------------
  // types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    RCD_FMT_I = 2'b00, RCD_FMT_J = 2'b01, RCD_FMT_R = 2'b10
  } rcd_fmt_t;

  typedef enum logic [3:0] {
    RCD_GRP_NONE = 4'b0000, RCD_GRP_LOAD = 4'b0001, RCD_GRP_STORE = 4'b0010,
    RCD_GRP_ALU_IMM = 4'b0011, RCD_GRP_ALU_REG = 4'b0100, RCD_GRP_SHIFT = 4'b0101,
    RCD_GRP_MULDIV = 4'b0110, RCD_GRP_JUMP = 4'b0111, RCD_GRP_BRANCH = 4'b1000,
    RCD_GRP_SYNC = 4'b1001
  } rcd_grp_t;

  typedef enum logic [2:0] {
    RCD_CND_NONE = 3'b000, RCD_CND_EQ = 3'b001, RCD_CND_NE = 3'b010, RCD_CND_LEZ = 3'b011,
    RCD_CND_GTZ = 3'b100, RCD_CND_LTZ = 3'b101, RCD_CND_GEZ = 3'b110, RCD_CND_ALWAYS = 3'b111
  } rcd_cond_t;

  typedef enum logic [1:0] {
    RCD_SLOT_IDLE = 2'b00, RCD_SLOT_NEXT = 2'b01, RCD_SLOT_NEXT_LIKELY = 2'b10
  } rcd_slot_t;

  typedef struct packed {
    rcd_fmt_t fmt;
    logic [5:0] opcode;
    logic [4:0] rs;
    logic [4:0] rt;
    logic [4:0] rd;
    logic [4:0] shamt;
    logic [5:0] funct;
    logic [15:0] imm;
    logic [25:0] target;
  } rcd_fields_t;

  typedef struct packed {
    rcd_fmt_t fmt;
    rcd_grp_t grp;
    rcd_cond_t cond;
    logic [5:0] opcode;
    logic [5:0] funct;
    logic [4:0] rs;
    logic [4:0] rt;
    logic [4:0] dst;
    logic wr_en;
    logic [63:0] imm;
    logic [5:0] shamt;
    logic shift_var;
    logic dword;
    logic unsigned_op;
    logic link;
    logic likely;
    logic [25:0] target;
    logic reserved;
  } rcd_ctrl_t;

endpackage

// file: rtl/rcd_field_split.sv
// format classifier and field extractor for one instruction word
// assumes a purely combinational context; the caller registers the result
`timescale 1ns/1ps
`default_nettype none

module rcd_field_split (
  input wire logic [31:0] instr_in,
  output var rcd_pkg::rcd_fields_t fields_out
);

  // ----------------------------------------------------------------------
  // format selection
  // ----------------------------------------------------------------------
  always_comb begin
    fields_out = '0;
    fields_out.opcode = instr_in[31:26];
    if (instr_in[31:26] == rcd_pkg::OP_SPECIAL) begin
      fields_out.fmt = rcd_pkg::RCD_FMT_R;
      fields_out.rs = instr_in[25:21];
      fields_out.rt = instr_in[20:16];
      fields_out.rd = instr_in[15:11];
      fields_out.shamt = instr_in[10:6];
      fields_out.funct = instr_in[5:0];
    end else if (instr_in[31:26] == rcd_pkg::OP_J || instr_in[31:26] == rcd_pkg::OP_JUMP_WITH_LINK) begin
      fields_out.fmt = rcd_pkg::RCD_FMT_J;
      fields_out.target = instr_in[25:0];
    end else begin
      fields_out.fmt = rcd_pkg::RCD_FMT_I;
      fields_out.rs = instr_in[25:21];
      fields_out.rt = instr_in[20:16];
      fields_out.imm = instr_in[15:0];
    end
  end

endmodule

`default_nettype wire

// file: bench/rcd_exec_model.sv
// execution-side model: resolves a likely branch two cycles after decode, ignoring any seen while a resolve is counting down
// assumes it shares clk_in and the clock enable with the decoder
`timescale 1ns/1ps
`default_nettype none

module rcd_exec_model (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic ce_in,
  input wire logic dec_valid_in,
  input wire rcd_pkg::rcd_ctrl_t dec_in,
  input wire logic take_in,
  output logic br_resolve_out,
  output logic br_taken_out
);
  // ----
  // resolve timer
  // ----
  logic [1:0] wait_q;
  always_ff @(posedge clk_in) begin
    br_resolve_out <= 1'b0;
    // taken toggles outside a resolve so a stale level is never trusted
    br_taken_out <= ~br_taken_out;
    if (!reset_n_in) begin
      wait_q <= 2'h0;
      br_taken_out <= 1'b0;
    end else if (ce_in && dec_valid_in && dec_in.likely && wait_q == 2'h0) begin
      wait_q <= 2'h2;
    end else if (wait_q != 2'h0) begin
      wait_q <= wait_q - 2'h1;
      if (wait_q == 2'h1) begin
        br_resolve_out <= 1'b1;
        br_taken_out <= take_in;
      end
    end
  end
endmodule
`default_nettype wire

// file: bench/testbench.sv
// self-checking bench: random decode stream against a behavioural model
// assumes the decoder and the execution-side model share one 250 MHz clock
`timescale 1ns/1ps
`default_nettype none

module testbench;
  logic clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic ce_in = 1'b1;
  logic instr_valid_in = 1'b0;
  logic [31:0] instr_in = 32'h0000_0000;
  logic take_q = 1'b0;
  logic br_resolve, br_taken, dec_valid_out, dec_slot_out, dec_nullify_out;
  rcd_pkg::rcd_ctrl_t dec_out, exp_c;
  logic [31:0] seed = 32'he013_5719;
  logic [31:0] w;
  logic ev = 1'b0, es = 1'b0, en = 1'b0, pend = 1'b0, lp = 1'b0;
  int failures = 0, samples_checked = 0, cycles = 0;
  logic [5:0] ops[18] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h04, 6'h06, 6'h08, 6'h0b, 6'h0c,
    6'h0f, 6'h19, 6'h20, 6'h37, 6'h1a, 6'h2b, 6'h3f, 6'h3b, 6'h10};
  logic [5:0] fns[17] = '{6'h00, 6'h03, 6'h07, 6'h09, 6'h08, 6'h18, 6'h1e, 6'h10, 6'h2a,
    6'h2b, 6'h2d, 6'h3c, 6'h3e, 6'h3f, 6'h0f, 6'h01, 6'h0c};
  logic [4:0] rts[5] = '{5'h00, 5'h01, 5'h10, 5'h11, 5'h08};

  initial forever #2 clk_in = ~clk_in;

  rcd_decode dut_u (.clk_in(clk_in), .reset_n_in(reset_n_in), .ce_in(ce_in),
    .instr_valid_in(instr_valid_in), .instr_in(instr_in), .br_resolve_in(br_resolve),
    .br_taken_in(br_taken), .dec_valid_out(dec_valid_out), .dec_out(dec_out),
    .dec_slot_out(dec_slot_out), .dec_nullify_out(dec_nullify_out));
  rcd_exec_model exec_u (.clk_in(clk_in), .reset_n_in(reset_n_in), .ce_in(ce_in),
    .dec_valid_in(dec_valid_out), .dec_in(dec_out), .take_in(take_q),
    .br_resolve_out(br_resolve), .br_taken_out(br_taken));

  // ----
  // behavioural model
  // ----
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic rcd_pkg::rcd_ctrl_t mdl(input logic [31:0] i);
    rcd_pkg::rcd_ctrl_t e;
    logic [5:0] op, fn;
    op = i[31:26];
    fn = i[5:0];
    e = '0;
    e.rs = i[25:21];
    e.rt = i[20:16];
    e.dst = i[15:11];
    e.imm = {{48{i[15]}}, i[15:0]};
    e.shamt = {fn[5] & fn[2], i[10:6]};
    e.shift_var = fn[2] & ~fn[5];
    e.fmt = rcd_pkg::RCD_FMT_I;
    if (op == 6'h00) begin
      e.fmt = rcd_pkg::RCD_FMT_R;
      e.dword = fn inside {[6'h2c:6'h2f]};
      e.link = fn == 6'h09;
      if (fn inside {[6'h00:6'h07], [6'h14:6'h17], [6'h38:6'h3f]} && fn[1:0] != 2'b01) e.grp = rcd_pkg::RCD_GRP_SHIFT;
      else if (fn[5:1] == 5'h04) e.grp = rcd_pkg::RCD_GRP_JUMP;
      else if (fn inside {[6'h10:6'h13], [6'h18:6'h1f]}) e.grp = rcd_pkg::RCD_GRP_MULDIV;
      else if (fn inside {[6'h20:6'h27], [6'h2a:6'h2f]}) e.grp = rcd_pkg::RCD_GRP_ALU_REG;
      else if (fn == 6'h0f) e.grp = rcd_pkg::RCD_GRP_SYNC;
    end else if (op == 6'h01) begin
      if (i[19:18] == 2'b00) begin
        e.grp = rcd_pkg::RCD_GRP_BRANCH;
        e.cond = i[16] ? rcd_pkg::RCD_CND_GEZ : rcd_pkg::RCD_CND_LTZ;
        e.likely = i[17];
        e.link = i[20];
        e.dst = 5'h1f;
      end
    end else if (op[5:1] == 5'h01) begin
      e.fmt = rcd_pkg::RCD_FMT_J;
      e.grp = rcd_pkg::RCD_GRP_JUMP;
      e.link = op[0];
      e.dst = 5'h1f;
    end else if (op[5:2] inside {4'h1, 4'h5}) begin
      e.grp = rcd_pkg::RCD_GRP_BRANCH;
      e.cond = rcd_pkg::rcd_cond_t'({1'b0, op[1:0]} + 3'h1);
      e.likely = op[4];
    end else if (op[5:3] == 3'b001 || op[5:1] == 5'h0c) begin
      e.grp = rcd_pkg::RCD_GRP_ALU_IMM;
      e.dword = op[4];
      if (op inside {[6'h0c:6'h0e]}) e.imm = {48'h0000_0000_0000, i[15:0]};
      if (op == 6'h0f) e.imm = {{32{i[15]}}, i[15:0], 16'h0000};
    end else if (op inside {6'h1a, 6'h1b, [6'h20:6'h27], 6'h30, 6'h34, 6'h37}) begin
      e.grp = rcd_pkg::RCD_GRP_LOAD;
    end else if (op inside {[6'h28:6'h2e], 6'h38, 6'h3c, 6'h3f}) begin
      e.grp = rcd_pkg::RCD_GRP_STORE;
    end
    e.reserved = e.grp == rcd_pkg::RCD_GRP_NONE;
    return e;
  endfunction

  task automatic chk(input logic ok, input string msg);
    samples_checked++;
    if (ok !== 1'b1) begin
      failures++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask

  task automatic complete_run;
    if (failures == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic send(input logic [31:0] i, input logic v, input logic c);
    @(posedge clk_in);
    instr_valid_in <= v;
    instr_in <= i;
    ce_in <= c;
  endtask

  // ----
  // cycle monitor: compare last edge's outcome, then step the model
  // ----
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 2000) begin
      failures++;
      complete_run();
    end
    if (cycles > 1) begin
      chk(dec_valid_out === ev, "valid");
      chk(dec_slot_out === es, "slot");
      chk(dec_nullify_out === en, "nullify");
    end
    if (ev && cycles > 1) begin
      chk(dec_out.reserved === exp_c.reserved && dec_out.grp === exp_c.grp, "group");
      if (!exp_c.reserved) chk(dec_out.fmt === exp_c.fmt, "format");
      if (exp_c.grp inside {rcd_pkg::RCD_GRP_LOAD, rcd_pkg::RCD_GRP_STORE, rcd_pkg::RCD_GRP_ALU_IMM})
        chk(dec_out.rs === exp_c.rs && dec_out.imm === exp_c.imm, "immediate");
      if (exp_c.grp == rcd_pkg::RCD_GRP_ALU_REG)
        chk(dec_out.wr_en === 1'b1 && dec_out.dst === exp_c.dst && dec_out.rt === exp_c.rt, "operands");
      if (exp_c.grp inside {rcd_pkg::RCD_GRP_ALU_REG, rcd_pkg::RCD_GRP_ALU_IMM})
        chk(dec_out.dword === exp_c.dword, "dword");
      if (exp_c.grp == rcd_pkg::RCD_GRP_SHIFT)
        chk(dec_out.shift_var === exp_c.shift_var && (exp_c.shift_var || dec_out.shamt === exp_c.shamt), "shift");
      if (exp_c.grp == rcd_pkg::RCD_GRP_BRANCH)
        chk(dec_out.cond === exp_c.cond && dec_out.likely === exp_c.likely, "branch");
      if (exp_c.grp inside {rcd_pkg::RCD_GRP_JUMP, rcd_pkg::RCD_GRP_BRANCH})
        chk(dec_out.link === exp_c.link && (!exp_c.link || dec_out.dst === exp_c.dst), "link");
    end
    if (!reset_n_in) begin
      {ev, es, en, pend, lp} = 5'b0_0000;
    end else if (ce_in) begin
      ev = instr_valid_in;
      es = 1'b0;
      en = br_resolve && lp && !br_taken;
      if (br_resolve) lp = 1'b0;
      if (instr_valid_in) begin
        exp_c = mdl(instr_in);
        es = pend;
        pend = exp_c.grp inside {rcd_pkg::RCD_GRP_JUMP, rcd_pkg::RCD_GRP_BRANCH} && !pend;
        if (exp_c.likely && !es) lp = 1'b1;
      end
    end
  end

  // ----
  // stimulus
  // ----
  initial begin
    repeat (4) @(posedge clk_in);
    reset_n_in <= 1'b1;
    for (int n = 0; n < 600; n++) begin
      seed = lfsr(seed);
      w = lfsr(seed);
      w = {ops[seed[15:8] % 18], w[25:0]};
      if (w[31:26] == 6'h00) w[5:0] = fns[seed[23:16] % 17];
      if (w[31:26] == 6'h01) w[20:16] = rts[seed[7:0] % 5];
      send(w, seed[28:27] != 2'b00, seed[31:29] != 3'b000);
      if (n == 300) begin
        reset_n_in <= 1'b0;
        send(w, 1'b1, 1'b1);
        reset_n_in <= 1'b1;
      end
    end
    // likely branches alone, each with a plain slot word and idle room to resolve
    for (int n = 0; n < 16; n++) begin
      seed = lfsr(seed);
      take_q <= n[3];
      w = n[2] ? {6'h01, seed[25:21], n[1], 2'b00, 1'b1, n[0], seed[15:0]} : {4'h5, n[1:0], seed[25:0]};
      send(w, 1'b1, 1'b1);
      send({6'h09, seed[31:6]}, 1'b1, 1'b1);
      repeat (4) send(w, 1'b0, 1'b1);
    end
    repeat (4) send(w, 1'b0, 1'b1);
    complete_run();
  end
endmodule
`default_nettype wire
